// File: rtl/cpc_regs.v
// control and status register bank for the camera d-phy receiver and demux shim
// assumes a single ahb-lite master; phy status levels and the link clock are
// asynchronous to clk_i and are synchronised here
//
// What this block does
// - status reports stop state of lane 1, lane 0 and clock lane.
// - status shows six-bit read-only termination control test field.
// - status shows per-lane data-correct test flags for lanes 2, 1, 0.
// - status shows read-only flag that bit clock exceeds threshold.
// - status shows oscillator clock ready and active flags.
// - shim flag sets on demux overflow, resets to zero.
// - phy reset release bit resets to zero; software writes one to release.
// - lane receiver enables reset to one; writing zero disables receiver.
// - polarity swap bits reset to zero; one swaps the pair wires.
// - three-bit clock lane pair select, resets to pair 1.
// - three-bit lane 0 pair select, resets to pair 0.
// - three-bit lane 1 pair select, resets to pair 2.
// - lane 1 and lane 0 settle precounters, eight bits, reset ten.
// - clock lane settle precounter, eight bits, resets to eleven.
`timescale 1ns/1ps
`include "cpc_consts.vh"

module cpc_regs (
	input  wire        clk_i,
	input  wire        nrst_i,
	// ahb-lite slave
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg  [31:0] hrdata_o,
	output reg         hreadyout_o,
	output reg         hresp_o,
	// phy status levels
	input  wire        lane1_stop_flag_i,
	input  wire        lane0_stop_flag_i,
	input  wire        clock_lane_stop_flag_i,
	input  wire [5:0]  term_ctrl_i,
	input  wire        lane2_data_ok_flag_i,
	input  wire        lane1_data_ok_flag_i,
	input  wire        lane0_data_ok_flag_i,
	input  wire        bit_clk_fast_flag_i,
	input  wire        osc_ready_flag_i,
	input  wire        osc_active_flag_i,
	// shim link clock and overflow level from the demux
	input  wire        link_clk_i,
	input  wire        demux_overflow_i,
	// phy controls
	output reg         phy_reset_release_o,
	output reg         always_on_reset_ctrl_o,
	output reg         lane1_rx_enable_o,
	output reg         lane0_rx_enable_o,
	output reg         clock_lane_rx_enable_o,
	output reg         lane1_polarity_swap_o,
	output reg         lane0_polarity_swap_o,
	output reg         clock_lane_polarity_swap_o,
	output reg  [2:0]  lane1_pair_select_o,
	output reg  [2:0]  lane0_pair_select_o,
	output reg  [2:0]  clock_lane_pair_select_o,
	output reg  [7:0]  lane1_settle_count_o,
	output reg  [7:0]  lane0_settle_count_o,
	output reg  [7:0]  clock_lane_settle_count_o,
	output reg         irq_o
);

	// register map, word index on haddr bits 17:2 (byte address = 4 * index):
	//   E013 phy status      read only, synchronised pin levels
	//   E014 shim status     bit 0 overflow, sticky, cleared by writing zero
	//   E018 reset control   bit 0 phy release, bit 1 always-on reset control
	//   E01B lane map        enables, polarity swaps and pair selects
	//   E01C settle counts   three eight-bit precounters
	//   E020 irq status      write one to clear
	//   E021 irq mask        same layout as irq status
	// any other index reads zero and ignores writes; the response is always
	// okay, so software probing a hole sees zero rather than a bus error.
	//
	// interrupt sources, one bit each in irq status and irq mask:
	//   bit 0 demux overflow seen at a rising shim clock edge
	//   bit 1 clock lane leaves its stop state
	//   bit 2 oscillator ready rises
	// irq_o is a registered level, high while any unmasked status bit is set.
	//
	// limitations a user must know:
	//   - the overflow flag clears only on a written zero; the demux does not
	//     recover by itself, so software must re-arm the shim after fixing the
	//     clock ratio, then clear the flag
	//   - control outputs follow their register one clock later, so a
	//     write is seen by the phy two clocks after its address phase is taken
	//   - nothing orders the always-on control against the phy release;
	//     bring-up software sets the always-on bit first
	//   - status levels are sampled, not latched: a pulse shorter than one
	//     clock may never show in a read
	//

	// register word select: haddr bits 17:2 against an index
	function cpc_hit;
		input [15:0] word;
		input [15:0] idx;
		begin
			cpc_hit = (word == idx);
		end
	endfunction

	// ---- input synchronisers ----
	wire [14:0] status_raw;
	reg  [14:0] status_meta;
	reg  [14:0] status_sync;
	reg  [1:0]  link_meta;
	reg  [1:0]  link_sync;
	reg         link_clk_prev;

	assign status_raw = {lane1_stop_flag_i, lane0_stop_flag_i,
		clock_lane_stop_flag_i, term_ctrl_i, lane2_data_ok_flag_i,
		lane1_data_ok_flag_i, lane0_data_ok_flag_i, bit_clk_fast_flag_i,
		osc_ready_flag_i, osc_active_flag_i};

	// two flops per level; the first stage feeds only the second
	// the link clock is oversampled: at 4 ns against 32 ns each level is
	// seen for several clocks, so no edge is lost across the two flops.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status_meta   <= 15'h0000;
			status_sync   <= 15'h0000;
			link_meta     <= 2'h0;
			link_sync     <= 2'h0;
			link_clk_prev <= 1'b0;
		end else begin
			status_meta   <= status_raw;
			status_sync   <= status_meta;
			link_meta     <= {link_clk_i, demux_overflow_i};
			link_sync     <= link_meta;
			link_clk_prev <= link_sync[1];
		end
	end

	// ---- start-up guard ----
	// after reset the synchronisers and the edge history hold zeros rather
	// than what the pins show; a pin already high (oscillator ready, a
	// running link clock) would otherwise look like a fresh rising edge.
	// events are ignored until both sync stages and the history flop have
	// been loaded from the pins, which costs three clocks after release.
	reg  [1:0] warm;
	wire       warm_done;

	assign warm_done = (warm == `CPC_WARM_DONE);

	// saturating count of clocks since reset release
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			warm <= 2'h0;
		else if (!warm_done)
			warm <= warm + 2'h1;
	end

	// overflow counts only when seen at a rising edge of the shim clock;
	// a level outside clocking is treated as not yet meaningful
	wire link_rise;
	wire overflow_evt;
	assign link_rise    = warm_done & link_sync[1] & ~link_clk_prev;
	assign overflow_evt = link_rise & link_sync[0];

	// ---- event detection for interrupts ----
	reg clk_stop_prev;
	reg osc_ready_prev;
	wire clk_stop_exit;
	wire osc_ready_rise;
	wire [`CPC_IRQ_WIDTH-1:0] irq_events;

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			clk_stop_prev  <= 1'b0;
			osc_ready_prev <= 1'b0;
		end else begin
			clk_stop_prev  <= status_sync[`CPC_ST_STOP_LSB];
			osc_ready_prev <= status_sync[`CPC_ST_OSCRDY_BIT];
		end
	end

	assign clk_stop_exit  = clk_stop_prev & ~status_sync[`CPC_ST_STOP_LSB];
	assign osc_ready_rise = ~osc_ready_prev & status_sync[`CPC_ST_OSCRDY_BIT];
	assign irq_events     = {osc_ready_rise & warm_done, clk_stop_exit & warm_done, overflow_evt};

	// ---- ahb-lite slave ----
	// one wait state per transfer: the write lands or the read data is
	// loaded in the cycle after the address phase; this avoids any
	// write-then-read forwarding at the cost of one cycle per access
	// cycle walk of one transfer, counting from the address edge:
	//   edge 1  address phase taken, hreadyout drops for one cycle
	//   edge 2  write lands from hwdata, or read data is loaded
	//   edge 3  master sees hready high and ends the data phase
	// a new address phase may be taken at edge 3 itself, so back-to-back
	// transfers run at one per two clocks.
	// hsize is not decoded: every access is treated as a whole word, and a
	// narrow write would overwrite the whole register.
	reg        pend;
	reg        pend_write;
	reg [15:0] pend_word;
	wire       accept;
	wire       wr_go;
	wire       rd_go;

	assign accept = hsel_i & htrans_i[1] & hready_i;
	assign wr_go  = pend & pend_write;
	assign rd_go  = pend & ~pend_write;

	// address phase capture and ready generation
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pend        <= 1'b0;
			pend_write  <= 1'b0;
			pend_word   <= 16'h0000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			hresp_o <= 1'b0;
			if (accept) begin
				pend        <= 1'b1;
				pend_write  <= hwrite_i;
				pend_word   <= haddr_i[17:2];
				hreadyout_o <= 1'b0;
			end else begin
				pend        <= 1'b0;
				hreadyout_o <= 1'b1;
			end
		end
	end

	// ---- register storage ----
	reg [1:0]                 reset_ctrl;
	reg [`CPC_LM_WIDTH-1:0]   lane_map;
	reg [23:0]                settle;
	reg                       shim_ovf;
	reg [`CPC_IRQ_WIDTH-1:0]  irq_status;
	reg [`CPC_IRQ_WIDTH-1:0]  irq_mask;

	// control registers written by software
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reset_ctrl <= `CPC_RST_RESET_CTRL;
			// enables one, swaps zero, pair selects 2/0/1
			lane_map   <= `CPC_RST_LANE_MAP;
			settle     <= `CPC_RST_SETTLE;
			irq_mask   <= {`CPC_IRQ_WIDTH{1'b0}};
		end else if (wr_go) begin
			if (cpc_hit(pend_word, `CPC_IDX_RESET_CTRL))
				reset_ctrl <= hwdata_i[1:0];
			if (cpc_hit(pend_word, `CPC_IDX_LANE_MAP))
				lane_map <= hwdata_i[`CPC_LM_WIDTH-1:0];
			if (cpc_hit(pend_word, `CPC_IDX_SETTLE))
				settle <= hwdata_i[23:0];
			if (cpc_hit(pend_word, `CPC_IDX_IRQ_MASK))
				irq_mask <= hwdata_i[`CPC_IRQ_WIDTH-1:0];
		end
	end

	// sticky flags; a new event in the clearing cycle wins
	// the clear of the shim flag is a written zero, unlike the interrupt
	// status, which is write-one-to-clear; the two follow different rules.
	wire shim_wr;
	wire irq_wr;
	assign shim_wr = wr_go & cpc_hit(pend_word, `CPC_IDX_SHIM_STATUS);
	assign irq_wr  = wr_go & cpc_hit(pend_word, `CPC_IDX_IRQ_STATUS);

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shim_ovf   <= 1'b0;
			irq_status <= {`CPC_IRQ_WIDTH{1'b0}};
		end else begin
			if (overflow_evt)
				shim_ovf <= 1'b1;
			else if (shim_wr && !hwdata_i[0])
				shim_ovf <= 1'b0;
			if (irq_wr)
				irq_status <= (irq_status & ~hwdata_i[`CPC_IRQ_WIDTH-1:0])
					| irq_events;
			else
				irq_status <= irq_status | irq_events;
		end
	end

	// ---- read mux ----
	// the mux looks at the captured word index, not the live bus, so the
	// read data always belong to the address phase that was taken even if
	// the master has already moved on to its next address.
	// reserved bits are padded with zeros here rather than in each register.
	reg [31:0] next_rdata;

	always @* begin
		next_rdata = 32'h00000000;
		// stop flags; term field; data ok; clock flags
		if (cpc_hit(pend_word, `CPC_IDX_PHY_STATUS))
			next_rdata = {17'h00000, status_sync};
		else if (cpc_hit(pend_word, `CPC_IDX_SHIM_STATUS))
			next_rdata = {31'h00000000, shim_ovf};
		else if (cpc_hit(pend_word, `CPC_IDX_RESET_CTRL))
			next_rdata = {30'h00000000, reset_ctrl};
		else if (cpc_hit(pend_word, `CPC_IDX_LANE_MAP))
			next_rdata = {17'h00000, lane_map};
		else if (cpc_hit(pend_word, `CPC_IDX_SETTLE))
			next_rdata = {8'h00, settle};
		else if (cpc_hit(pend_word, `CPC_IDX_IRQ_STATUS))
			next_rdata = {29'h00000000, irq_status};
		else if (cpc_hit(pend_word, `CPC_IDX_IRQ_MASK))
			next_rdata = {29'h00000000, irq_mask};
	end

	// read data loaded in the wait cycle, held until the next read
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			hrdata_o <= 32'h00000000;
		else if (rd_go)
			hrdata_o <= next_rdata;
	end

	// ---- control outputs, one flop behind the registers ----
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phy_reset_release_o        <= 1'b0;
			always_on_reset_ctrl_o     <= 1'b0;
			lane1_rx_enable_o          <= 1'b1;
			lane0_rx_enable_o          <= 1'b1;
			clock_lane_rx_enable_o     <= 1'b1;
			lane1_polarity_swap_o      <= 1'b0;
			lane0_polarity_swap_o      <= 1'b0;
			clock_lane_polarity_swap_o <= 1'b0;
			lane1_pair_select_o        <= 3'h2;
			lane0_pair_select_o        <= 3'h0;
			clock_lane_pair_select_o   <= 3'h1;
			lane1_settle_count_o       <= 8'h0A;
			lane0_settle_count_o       <= 8'h0A;
			clock_lane_settle_count_o  <= 8'h0B;
			irq_o                      <= 1'b0;
		end else begin
			// phy release; ordering left to software
			phy_reset_release_o        <= reset_ctrl[`CPC_RC_RELEASE_BIT];
			always_on_reset_ctrl_o     <= reset_ctrl[`CPC_RC_ALWAYS_ON_BIT];
			lane1_rx_enable_o          <= lane_map[`CPC_LM_EN_L1_BIT];
			lane0_rx_enable_o          <= lane_map[`CPC_LM_EN_L0_BIT];
			clock_lane_rx_enable_o     <= lane_map[`CPC_LM_EN_CLK_BIT];
			lane1_polarity_swap_o      <= lane_map[`CPC_LM_SW_L1_BIT];
			lane0_polarity_swap_o      <= lane_map[`CPC_LM_SW_L0_BIT];
			clock_lane_polarity_swap_o <= lane_map[`CPC_LM_SW_CLK_BIT];
			lane1_pair_select_o        <= lane_map[`CPC_LM_L1_LSB +: 3];
			lane0_pair_select_o        <= lane_map[`CPC_LM_L0_LSB +: 3];
			clock_lane_pair_select_o   <= lane_map[`CPC_LM_CLK_LSB +: 3];
			lane1_settle_count_o       <= settle[`CPC_SET_L1_LSB +: 8];
			lane0_settle_count_o       <= settle[`CPC_SET_L0_LSB +: 8];
			clock_lane_settle_count_o  <= settle[`CPC_SET_CLK_LSB +: 8];
			irq_o                      <= |(irq_status & irq_mask);
		end
	end

endmodule

// File: pkg/cpc_consts.vh
// register indices, field positions and reset values of the phy control bank
// assumes byte address = 4 * index on a 32-bit ahb-lite bus
`ifndef CPC_CONSTS_VH
`define CPC_CONSTS_VH

// register indices (word addresses)
`define CPC_IDX_PHY_STATUS   16'hE013
`define CPC_IDX_SHIM_STATUS  16'hE014
`define CPC_IDX_RESET_CTRL   16'hE018
`define CPC_IDX_LANE_MAP     16'hE01B
`define CPC_IDX_SETTLE       16'hE01C
`define CPC_IDX_IRQ_STATUS   16'hE020
`define CPC_IDX_IRQ_MASK     16'hE021

// status register fields
`define CPC_ST_STOP_LSB      12
`define CPC_ST_TERM_LSB      6
`define CPC_ST_DATAOK_LSB    3
`define CPC_ST_FAST_BIT      2
`define CPC_ST_OSCRDY_BIT    1
`define CPC_ST_OSCACT_BIT    0

// reset control fields
`define CPC_RC_RELEASE_BIT   0
`define CPC_RC_ALWAYS_ON_BIT 1

// lane map fields
`define CPC_LM_EN_L1_BIT     14
`define CPC_LM_EN_L0_BIT     13
`define CPC_LM_EN_CLK_BIT    12
`define CPC_LM_SW_L1_BIT     11
`define CPC_LM_SW_L0_BIT     10
`define CPC_LM_SW_CLK_BIT    9
`define CPC_LM_L1_LSB        6
`define CPC_LM_L0_LSB        3
`define CPC_LM_CLK_LSB       0
`define CPC_LM_WIDTH         15

// settle fields
`define CPC_SET_L1_LSB       16
`define CPC_SET_L0_LSB       8
`define CPC_SET_CLK_LSB      0

// reset values
`define CPC_RST_RESET_CTRL   2'h0
`define CPC_RST_LANE_MAP     15'h7081
`define CPC_RST_SETTLE       24'h0A0A0B

// interrupt status bits
`define CPC_IRQ_OVF_BIT      0
`define CPC_IRQ_STOPX_BIT    1
`define CPC_IRQ_OSCRDY_BIT   2
`define CPC_IRQ_WIDTH        3

// clocks after reset release before pin edges are trusted
`define CPC_WARM_DONE        2'h3

`endif

// File: verif/cpc_regs_sva.sv
// port checker for the phy control register bank
// assumes a single ahb-lite master with hready_i tied to hreadyout_o
`timescale 1ns/1ps
module cpc_regs_sva (
	input wire       clk_i,
	input wire       nrst_i,
	input wire       hsel_i,
	input wire [1:0] htrans_i,
	input wire       hwrite_i,
	input wire       hready_i,
	input wire       hreadyout_o,
	input wire       hresp_o,
	input wire       phy_reset_release_o,
	input wire       lane0_rx_enable_o,
	input wire       lane1_polarity_swap_o,
	input wire [2:0] clock_lane_pair_select_o,
	input wire [7:0] lane0_settle_count_o,
	input wire       irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// taken transfers; control outputs may only move a few edges after a write
	wire tk = hsel_i & htrans_i[1] & hready_i;
	wire wr = tk & hwrite_i;

	AST_ONE_WAIT: assert property (tk |=> !hreadyout_o ##1 hreadyout_o)
		else $error("wait state not one cycle");
	AST_OKAY: assert property (hresp_o == 1'b0)
		else $error("response not okay");
	AST_RST_RELEASE: assert property ($rose(nrst_i) |-> !phy_reset_release_o)
		else $error("phy not held in reset");
	AST_RST_ENABLE: assert property ($rose(nrst_i) |-> lane0_rx_enable_o)
		else $error("receiver not enabled at reset");
	AST_RST_SWAP: assert property ($rose(nrst_i) |-> !lane1_polarity_swap_o)
		else $error("swap set at reset");
	AST_RST_PAIR: assert property ($rose(nrst_i) |-> clock_lane_pair_select_o == 3'h1)
		else $error("clock pair wrong at reset");
	AST_SETTLE_BY_WRITE: assert property ($changed(lane0_settle_count_o) |->
		$past(wr, 2) || $past(wr, 3) || $past(wr, 4)) else $error("settle moved without write");
	AST_PAIR_STABLE: assert property ((!wr)[*4] |=> $stable(clock_lane_pair_select_o))
		else $error("pair select moved without write");
	AST_IRQ_HOLD: assert property ($fell(irq_o) |->
		$past(wr, 2) || $past(wr, 3) || $past(wr, 4)) else $error("irq dropped without write");
endmodule

bind cpc_regs cpc_regs_sva u_sva (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .phy_reset_release_o(phy_reset_release_o),
	.lane0_rx_enable_o(lane0_rx_enable_o), .lane1_polarity_swap_o(lane1_polarity_swap_o),
	.clock_lane_pair_select_o(clock_lane_pair_select_o),
	.lane0_settle_count_o(lane0_settle_count_o), .irq_o(irq_o));

// File: verif/cpc_cam_model.sv
// camera transmitter model: link clock, overflow level and lane stop flags
// assumes the bench frames traffic with frame_i
`timescale 1ns/1ps
module cpc_cam_model (
	input  wire logic  frame_i,
	input  wire logic  ovf_i,
	output logic       link_clk_o,
	output logic       overflow_o,
	output logic [2:0] stop_o
);
	// clock parks low between frames; the 3 ns offset keeps edges off clk_i edges
	initial begin
		link_clk_o = 1'b0;
		#3;
		forever begin
			#16;
			link_clk_o = frame_i ? ~link_clk_o : 1'b0;
		end
	end
	// overflow only reported while traffic flows
	assign overflow_o = frame_i & ovf_i;
	// lanes sit in stop state outside a frame
	assign stop_o = {3{~frame_i}};
endmodule

// File: verif/tb_top.sv
// self-checking bench for the phy control register bank
// assumes the camera model supplies link clock, overflow and stop flags
`timescale 1ns/1ps
`include "cpc_consts.vh"
module tb_top;
	typedef struct packed {logic [15:0] ix; logic [31:0] wd; logic [31:0] ex;} cpc_row_t;
	logic        clk_i, nrst_i, hsel_i, hwrite_i, frame, ovf;
	logic [1:0]  htrans_i;
	logic [31:0] haddr_i, hwdata_i, rd;
	logic [11:0] pin;
	wire  [31:0] hrdata_o;
	wire         hreadyout_o, lclk, dovf, irq_o;
	wire  [2:0]  stp;
	wire  [40:0] outs;
	int          fails, checks, i;
	cpc_row_t    rows [10] = '{
		'{`CPC_IDX_RESET_CTRL, 32'h2, 32'h2}, '{`CPC_IDX_RESET_CTRL, 32'hFFFFFFFF, 32'h3},
		'{`CPC_IDX_LANE_MAP, 32'hFFFFFFFF, 32'h7FFF}, '{`CPC_IDX_LANE_MAP, 32'h0, 32'h0},
		'{`CPC_IDX_SETTLE, 32'hFFFFFFFF, 32'hFFFFFF}, '{`CPC_IDX_SETTLE, 32'h12345678, 32'h345678},
		'{`CPC_IDX_PHY_STATUS, 32'hFFFFFFFF, 32'h7A5A}, '{`CPC_IDX_SHIM_STATUS, 32'h1, 32'h0},
		'{`CPC_IDX_IRQ_MASK, 32'hFFFFFFFF, 32'h7}, '{16'h0001, 32'hFFFFFFFF, 32'h0}};

	cpc_cam_model u_cam (.frame_i(frame), .ovf_i(ovf), .link_clk_o(lclk), .overflow_o(dovf),
		.stop_o(stp));
	cpc_regs DUT (.clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
		.hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o(),
		.lane1_stop_flag_i(stp[2]), .lane0_stop_flag_i(stp[1]), .clock_lane_stop_flag_i(stp[0]),
		.term_ctrl_i(pin[11:6]), .lane2_data_ok_flag_i(pin[5]), .lane1_data_ok_flag_i(pin[4]),
		.lane0_data_ok_flag_i(pin[3]), .bit_clk_fast_flag_i(pin[2]), .osc_ready_flag_i(pin[1]),
		.osc_active_flag_i(pin[0]), .link_clk_i(lclk), .demux_overflow_i(dovf),
		.phy_reset_release_o(outs[40]), .always_on_reset_ctrl_o(outs[39]),
		.lane1_rx_enable_o(outs[38]), .lane0_rx_enable_o(outs[37]),
		.clock_lane_rx_enable_o(outs[36]), .lane1_polarity_swap_o(outs[35]),
		.lane0_polarity_swap_o(outs[34]), .clock_lane_polarity_swap_o(outs[33]),
		.lane1_pair_select_o(outs[32:30]), .lane0_pair_select_o(outs[29:27]),
		.clock_lane_pair_select_o(outs[26:24]), .lane1_settle_count_o(outs[23:16]),
		.lane0_settle_count_o(outs[15:8]), .clock_lane_settle_count_o(outs[7:0]), .irq_o);

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task results;
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [63:0] got, input logic [63:0] ex);
		checks++;
		if (got !== ex) begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, ex);
		end
	endtask

	// bounded wait for hready high at a rising edge
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			results();
		end
	endtask

	// one single word transfer; read data taken at the edge ending the data phase
	task ahb(input logic w, input logic [15:0] ix, input logic [31:0] wd);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {14'h0, ix, 2'h0};
		wt();
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		wt();
		rd = hrdata_o;
	endtask

	initial begin
		{nrst_i, hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i, frame, ovf} = '0;
		pin = 12'hA5A;
		fails = 0;
		checks = 0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		chk(outs, 41'h070810A0A0B);
		for (i = 0; i < 10; i++) begin
			ahb(1'b1, rows[i].ix, rows[i].wd);
			ahb(1'b0, rows[i].ix, 32'h0);
			chk(rd, rows[i].ex);
		end
		repeat (2) @(posedge clk_i);
		chk(outs, 41'h18000345678);
		// second reset in mid-run
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		chk(outs, 41'h070810A0A0B);
		ahb(1'b0, `CPC_IDX_RESET_CTRL, 32'h0);
		chk(rd, 32'h0);
		// frame running, lanes leave stop state, status pins inverted
		frame <= 1'b1;
		pin <= 12'h5A5;
		repeat (4) @(posedge clk_i);
		ahb(1'b0, `CPC_IDX_PHY_STATUS, 32'h0);
		chk(rd, 32'h5A5);
		ahb(1'b1, `CPC_IDX_IRQ_STATUS, 32'h7);
		ahb(1'b1, `CPC_IDX_IRQ_MASK, 32'h1);
		ovf <= 1'b1;
		repeat (40) @(posedge clk_i);
		ovf <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(irq_o, 1'b1);
		ahb(1'b0, `CPC_IDX_IRQ_STATUS, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b1, `CPC_IDX_SHIM_STATUS, 32'h1);
		ahb(1'b0, `CPC_IDX_SHIM_STATUS, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b1, `CPC_IDX_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		ahb(1'b1, `CPC_IDX_SHIM_STATUS, 32'h0);
		ahb(1'b0, `CPC_IDX_SHIM_STATUS, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b1, `CPC_IDX_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b1);
		ahb(1'b1, `CPC_IDX_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		frame <= 1'b0;
		results();
	end
endmodule
